// *** logic/gpio_port_regs.svh ***
// register offsets, reset values and field positions of the port block
//
// Notes on behaviour
// - a pin is plain port i/o only when the crossbar has not claimed it and no analog use holds it.
// - port data registers sit at 0x80, 0x90 and 0xa0 and take both byte and single-bit access.
// - a write stores into the output latch, which keeps driving the pins until written again.
// - an ordinary read returns the pin levels, whatever the crossbar settings are.
// - logic, jump-and-clear, complement, increment, decrement, loop ops and bit moves count as read-modify-write.
// - a read-modify-write takes its operand from the latch, not the pins, and writes the result back.
// - each port 0 drive-select bit picks open-drain at 0 and push-pull at 1, bit n for pin n.
// - a port 0 drive-select bit is ignored while its analog-digital select bit is 0.
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH
`define ADDR_PORT_ZERO_LATCH 8'h80
`define ADDR_PORT_ONE_LATCH 8'h90
`define ADDR_PORT_TWO_LATCH 8'ha0
`define ADDR_PORT_ZERO_DRIVE_SELECT 8'ha4
`define RST_PORT_ZERO_LATCH 8'hff
`define RST_PORT_ONE_LATCH 8'hff
`define RST_PORT_TWO_LATCH 1'b1
`define RST_PORT_ZERO_DRIVE_SELECT 8'h00
`define PORT_TWO_PIN_BIT 0
`endif

// *** logic/gpio_port_pkg.sv ***
// types shared by the port block
`default_nettype none
package gpio_port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] bit_index_t;
endpackage : gpio_port_pkg
`default_nettype wire

// *** logic/pin_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** logic/general_purpose_port_io.sv ***
// port i/o block: latches, pin reads, read-modify-write and drive modes
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.svh"
module general_purpose_port_io
  import gpio_port_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // special function register access from the core
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic sfr_bit_op,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // crossbar, analog and port 1 drive-select configuration
  input wire logic [7:0] port_zero_crossbar_claim,
  input wire logic [7:0] port_one_crossbar_claim,
  input wire logic port_two_crossbar_claim,
  input wire logic [7:0] port_zero_crossbar_out,
  input wire logic [7:0] port_one_crossbar_out,
  input wire logic port_two_crossbar_out,
  input wire logic [7:0] port_zero_analog_digital_select,
  input wire logic [7:0] port_one_analog_digital_select,
  input wire logic [7:0] port_one_drive_select,
  // port pins
  input wire logic [7:0] port_zero_pin_in,
  output logic [7:0] port_zero_pin_out,
  output logic [7:0] port_zero_pin_oe,
  input wire logic [7:0] port_one_pin_in,
  output logic [7:0] port_one_pin_out,
  output logic [7:0] port_one_pin_oe,
  input wire logic port_two_pin_in,
  output logic port_two_pin_out,
  output logic port_two_pin_oe
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  byte_t p0_sync;
  byte_t p1_sync;
  logic [0:0] p2_sync;
  pin_sync #(.WIDTH(8)) u_sync_p0 (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .async_in(port_zero_pin_in),
    .sync_out(p0_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_p1 (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .async_in(port_one_pin_in),
    .sync_out(p1_sync)
  );
  pin_sync #(.WIDTH(1)) u_sync_p2 (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .async_in(port_two_pin_in),
    .sync_out(p2_sync)
  );

  // ****************************************
  // address decode
  // ****************************************
  byte_t p0_latch_q;
  byte_t p1_latch_q;
  logic p2_latch_q;
  byte_t p0_drive_q;
  wire sel_p0 = (sfr_addr == `ADDR_PORT_ZERO_LATCH);
  wire sel_p1 = (sfr_addr == `ADDR_PORT_ONE_LATCH);
  wire sel_p2 = (sfr_addr == `ADDR_PORT_TWO_LATCH);
  wire sel_md = (sfr_addr == `ADDR_PORT_ZERO_DRIVE_SELECT);

  // ****************************************
  // read paths
  // ****************************************
  // analog pins read as zero; crossbar claim does not hide the pin
  wire [7:0] p0_pin_view = p0_sync & port_zero_analog_digital_select;
  wire [7:0] p1_pin_view = p1_sync & port_one_analog_digital_select;
  wire [7:0] p2_pin_view = {7'h00, p2_sync[0]};
  wire [7:0] p2_latch_view = {7'h00, p2_latch_q};
  // read-modify-write sees the latch, ordinary reads see the pins
  wire [7:0] p0_read = sfr_rmw ? p0_latch_q : p0_pin_view;
  wire [7:0] p1_read = sfr_rmw ? p1_latch_q : p1_pin_view;
  wire [7:0] p2_read = sfr_rmw ? p2_latch_view : p2_pin_view;
  wire [7:0] rdata_d;
  assign rdata_d = sel_p0 ? p0_read :
                   sel_p1 ? p1_read :
                   sel_p2 ? p2_read :
                   sel_md ? p0_drive_q : 8'h00;

  // ****************************************
  // write paths
  // ****************************************
  // single-bit writes merge into the latch so other bits keep their value
  wire [7:0] bit_mask = 8'h01 << sfr_bit_sel;
  wire [7:0] bit_val = sfr_wdata[0] ? bit_mask : 8'h00;
  wire [7:0] p0_wval = sfr_bit_op ? ((p0_latch_q & ~bit_mask) | bit_val) : sfr_wdata;
  wire [7:0] p1_wval = sfr_bit_op ? ((p1_latch_q & ~bit_mask) | bit_val) : sfr_wdata;
  wire [7:0] p2_wval = sfr_bit_op ? ((p2_latch_view & ~bit_mask) | bit_val) : sfr_wdata;
  wire [7:0] md_wval = sfr_bit_op ? ((p0_drive_q & ~bit_mask) | bit_val) : sfr_wdata;
  // unmapped addresses raise no enable, so such writes vanish
  wire wr_p0 = sfr_wr && sel_p0;
  wire wr_p1 = sfr_wr && sel_p1;
  wire wr_p2 = sfr_wr && sel_p2;
  wire wr_md = sfr_wr && sel_md;

  // ****************************************
  // port latches and drive select
  // ****************************************
  // a write and a read-modify-write read may share a cycle; the read sees the old latch
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      p0_latch_q <= `RST_PORT_ZERO_LATCH;
    end else if (wr_p0) begin
      p0_latch_q <= p0_wval;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      p1_latch_q <= `RST_PORT_ONE_LATCH;
    end else if (wr_p1) begin
      p1_latch_q <= p1_wval;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      p2_latch_q <= `RST_PORT_TWO_LATCH;
    end else if (wr_p2) begin
      p2_latch_q <= p2_wval[`PORT_TWO_PIN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      p0_drive_q <= `RST_PORT_ZERO_DRIVE_SELECT;
    end else if (wr_md) begin
      p0_drive_q <= md_wval;
    end
  end

  // ****************************************
  // read data register
  // ****************************************
  // holds until the next read, so the core may take it late
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_d;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // analog pins never drive; drive select only matters on digital pins
  wire [7:0] p0_pp = p0_drive_q & port_zero_analog_digital_select;
  wire [7:0] p1_pp = port_one_drive_select & port_one_analog_digital_select;
  wire [7:0] p0_val = port_zero_crossbar_claim & port_zero_crossbar_out |
                      ~port_zero_crossbar_claim & p0_latch_q;
  wire [7:0] p1_val = port_one_crossbar_claim & port_one_crossbar_out |
                      ~port_one_crossbar_claim & p1_latch_q;
  wire p2_val = port_two_crossbar_claim ? port_two_crossbar_out : p2_latch_q;
  wire [7:0] p0_oe_d = port_zero_analog_digital_select & (~p0_val | p0_pp);
  wire [7:0] p1_oe_d = port_one_analog_digital_select & (~p1_val | p1_pp);
  // port 2 has no drive-select register here, so it stays open-drain
  wire p2_oe_d = ~p2_val;

  // ****************************************
  // pin output registers
  // ****************************************
  // nothing drives during reset, so no pin glitches before the latch is known
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port_zero_pin_out <= 8'h00;
      port_zero_pin_oe <= 8'h00;
    end else begin
      port_zero_pin_out <= p0_val;
      port_zero_pin_oe <= p0_oe_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port_one_pin_out <= 8'h00;
      port_one_pin_oe <= 8'h00;
    end else begin
      port_one_pin_out <= p1_val;
      port_one_pin_oe <= p1_oe_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port_two_pin_out <= 1'b0;
      port_two_pin_oe <= 1'b0;
    end else begin
      port_two_pin_out <= p2_val;
      port_two_pin_oe <= p2_oe_d;
    end
  end
endmodule : general_purpose_port_io
`default_nettype wire

// *** tb/gpio_port_props.sv ***
// assertions on the port block ports
`timescale 1ns/1ps
`default_nettype none
module gpio_port_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register access
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic sfr_bit_op,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // configuration
  input wire logic [7:0] port_zero_analog_digital_select,
  input wire logic [7:0] port_one_analog_digital_select,
  input wire logic [7:0] port_one_crossbar_claim,
  input wire logic [7:0] port_one_crossbar_out,
  input wire logic [7:0] port_one_drive_select,
  // pins
  input wire logic [7:0] port_zero_pin_in,
  input wire logic [7:0] port_zero_pin_out,
  input wire logic [7:0] port_zero_pin_oe,
  input wire logic [7:0] port_one_pin_out,
  input wire logic [7:0] port_one_pin_oe,
  input wire logic port_two_pin_out,
  input wire logic port_two_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_WR_LATCH: assert property (sfr_wr && !sfr_rd && !sfr_bit_op && sfr_addr == 8'h80
    |-> ##2 port_zero_pin_out == $past(sfr_wdata, 2)) else $error("latch not on pins");
  AST_RD_PIN: assert property ($stable(port_zero_pin_in)[*3] ##0 (sfr_rd && !sfr_rmw
    && sfr_addr == 8'h80) |=> sfr_rdata == ($past(port_zero_pin_in)
    & $past(port_zero_analog_digital_select))) else $error("pin read wrong");
  AST_UNMAPPED: assert property (sfr_rd && !(sfr_addr inside {8'h80, 8'h90, 8'ha0, 8'ha4})
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  AST_P2_UPPER: assert property (sfr_rd && sfr_addr == 8'ha0
    |=> sfr_rdata[7:1] == 7'h00) else $error("port two upper bits set");
  AST_DRIVE: assert property ($past(rst_n, 6) && port_one_crossbar_claim == 8'h00
    && $stable(port_one_crossbar_claim) && $stable(port_one_drive_select)
    && $stable(port_one_analog_digital_select) |-> port_one_pin_oe ==
    (port_one_analog_digital_select & (~port_one_pin_out | port_one_drive_select)))
    else $error("drive enable wrong");
  AST_P2_OPEN: assert property (port_two_pin_oe |-> !port_two_pin_out)
    else $error("port two drives high");
  AST_CLAIM: assert property (port_one_crossbar_claim[0] && $past(port_one_crossbar_claim[0])
    && $stable(port_one_crossbar_out[0]) |-> port_one_pin_out[0] == port_one_crossbar_out[0])
    else $error("claimed pin not crossbar");
  AST_ANALOG: assert property (!port_zero_analog_digital_select[1]
    && !$past(port_zero_analog_digital_select[1]) |-> !port_zero_pin_oe[1])
    else $error("analog pin driven");
endmodule : gpio_port_props
bind general_purpose_port_io gpio_port_props props (.*);
`default_nettype wire

// *** tb/pin_board.sv ***
// board side of one port: pull-ups and an external driver
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // external driver
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // level seen by the device
  output logic [7:0] pin_in
);
  // wired-and: released lines float up, so a stuck latch bit shows
  assign pin_in = ~((pin_oe & ~pin_out) | (ext_en & ~ext_val));
endmodule : pin_board
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0, bop = 1'b0;
  logic [2:0] bsel = 3'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00, p0_ad = 8'hff, p1_ad = 8'hff, p1_pp = 8'h00;
  logic [7:0] p1_cl = 8'h00, p1_xo = 8'h00, e0 = 8'h00, e1 = 8'h00, v1 = 8'h00;
  logic [7:0] rdata, p0_o, p0_e, p0_i, p1_o, p1_e, p1_i;
  logic [7:0] p0_cl = 8'h00, p0_xo = 8'h00;
  logic p2_cl = 1'b0, p2_xo = 1'b0;
  logic p2_o, p2_e, p2_i;
  int mismatches = 0, compares = 0, cycles = 0;
  always #4 ref_clk = ~ref_clk;
  assign p2_i = p2_e ? p2_o : 1'b1;
  pin_board b0 (.pin_out(p0_o), .pin_oe(p0_e), .ext_en(e0), .ext_val(8'h00), .pin_in(p0_i));
  pin_board b1 (.pin_out(p1_o), .pin_oe(p1_e), .ext_en(e1), .ext_val(v1), .pin_in(p1_i));
  general_purpose_port_io dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(addr),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rmw(rmw), .sfr_bit_op(bop), .sfr_bit_sel(bsel),
    .sfr_wdata(wd), .sfr_rdata(rdata), .port_zero_crossbar_claim(p0_cl),
    .port_one_crossbar_claim(p1_cl), .port_two_crossbar_claim(p2_cl),
    .port_zero_crossbar_out(p0_xo), .port_one_crossbar_out(p1_xo),
    .port_two_crossbar_out(p2_xo), .port_zero_analog_digital_select(p0_ad),
    .port_one_analog_digital_select(p1_ad), .port_one_drive_select(p1_pp),
    .port_zero_pin_in(p0_i), .port_zero_pin_out(p0_o), .port_zero_pin_oe(p0_e),
    .port_one_pin_in(p1_i), .port_one_pin_out(p1_o), .port_one_pin_oe(p1_e),
    .port_two_pin_in(p2_i), .port_two_pin_out(p2_o), .port_two_pin_oe(p2_e));
  task automatic op(input logic [7:0] a, input logic w, r, m, b, input logic [2:0] s,
                    input logic [7:0] d);
    // lead time lets a board or config change reach the synchronised pins
    repeat (3) @(negedge ref_clk);
    {addr, wr, rd, rmw, bop, bsel, wd} = {a, w, r, m, b, s, d};
    @(negedge ref_clk);
    {wr, rd, rmw, bop} = 4'h0;
    // settle time covers two pin stages plus the synchroniser
    repeat (4) @(negedge ref_clk);
  endtask : op
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic t_reset();
    op(8'h90, 0, 1, 1, 0, 0, 0); chk(rdata, 8'hff);
    op(8'ha4, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h00);
  endtask : t_reset
  task automatic t_p0();
    op(8'ha4, 1, 0, 0, 0, 0, 8'h0f);
    op(8'h80, 1, 0, 0, 0, 0, 8'h5a); chk(p0_e, 8'haf);
    chk(p0_o, 8'h5a);
    e0 = 8'h40;
    op(8'h80, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h1a);
    op(8'h80, 0, 1, 1, 0, 0, 0); chk(rdata, 8'h5a);
    {e0, p0_cl, p0_xo} = {8'h00, 8'h01, 8'h01};
    op(8'h80, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h5b);
    chk(p0_o, 8'h5b);
    op(8'h80, 0, 1, 1, 0, 0, 0); chk(rdata, 8'h5a);
    p0_cl = 8'h00;
  endtask : t_p0
  task automatic t_bit();
    {e1, v1} = {8'hff, 8'h00};
    op(8'h90, 1, 1, 1, 1, 3'h3, 8'h00);
    op(8'h90, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h00);
    op(8'h90, 0, 1, 1, 0, 0, 0); chk(rdata, 8'hf7);
    {e1, p1_pp, p1_ad} = {8'h00, 8'hff, 8'h7f};
    op(8'h90, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h77);
    chk(p1_e, 8'h7f);
    p1_cl = 8'h01;
    op(8'h90, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h76);
    chk(p1_o, 8'hf6);
    p1_cl = 8'h00;
  endtask : t_bit
  task automatic t_p2();
    op(8'ha0, 1, 0, 0, 0, 0, 8'h00); chk({p2_e, p2_o}, 8'h02);
    op(8'ha0, 0, 1, 1, 0, 0, 0); chk(rdata, 8'h00);
    {p2_cl, p2_xo} = 2'b11;
    op(8'ha0, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h01);
    chk({p2_e, p2_o}, 8'h01);
    {p2_cl, p2_xo} = 2'b00;
    op(8'ha0, 1, 0, 0, 0, 0, 8'hff);
    op(8'ha0, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h01);
    op(8'h55, 1, 0, 0, 0, 0, 8'hff);
    op(8'h55, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h00);
  endtask : t_p2
  task automatic t_analog();
    p0_ad = 8'hfd;
    op(8'h80, 0, 1, 0, 0, 0, 0); chk(rdata, 8'h58);
    chk(p0_e, 8'had);
  endtask : t_analog
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    t_reset();
    t_p0();
    t_bit();
    t_p2();
    t_analog();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
